// file: mcu_alu_return_subset.sv
// Contract
// - Subroutine exit pops the stack into the PC; flags untouched.
// - Subroutine exit takes two instruction cycles before the next issue.
// - Literal minus accumulator into accumulator; carry, digit carry, zero.
// - File minus accumulator to destination; carry, digit carry, zero.
// - Rotate file right through carry to destination; only carry changes.
// - Destination bit 0 writes accumulator, 1 writes the file register.
// - Nibble exchange swaps file nibbles to destination; no flag changes.
// - File xor accumulator to destination; only zero flag changes.
// - Literal xor accumulator into accumulator; only zero flag changes.
// - File addresses are 7 bits wide, literals are 8 bits wide.
`timescale 1ns/1ps
`include "mcu_alu_return_subset_consts.svh"

module mcu_alu_return_subset #(
   parameter int FADDR_W = 7,
   parameter int PC_W = 13,
   parameter int STACK_DEPTH = 8,
   parameter int SP_W = 3
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // Instruction issue
   input wire logic i_issue,
   input wire mcu_alu_pkg::op_t i_op,
   input wire logic [7:0] i_literal,
   input wire logic [FADDR_W-1:0] i_faddr,
   input wire logic i_dest,
   output logic o_ready,
   output logic o_done,
   // Subroutine entry, pushes a return address
   input wire logic i_call,
   input wire logic [PC_W-1:0] i_call_target,
   input wire logic [PC_W-1:0] i_call_return,
   // Preload of accumulator and file registers
   input wire logic i_acc_wr,
   input wire logic [7:0] i_acc_wdata,
   input wire logic i_file_wr,
   input wire logic [FADDR_W-1:0] i_file_waddr,
   input wire logic [7:0] i_file_wdata,
   // File register inspection, one cycle latency
   input wire logic [FADDR_W-1:0] i_peek_addr,
   output logic [7:0] o_peek_data,
   // Architectural state
   output logic [7:0] o_acc,
   output logic o_carry,
   output logic o_digit_carry_flag,
   output logic o_zero,
   output logic [PC_W-1:0] o_pc,
   output logic [SP_W-1:0] o_stack_ptr
);

   localparam int NREG = 2 ** FADDR_W;

   typedef struct packed {
      mcu_alu_pkg::state_t st;
      logic [1:0] wait_cnt;
      logic [PC_W-1:0] pc;
      logic [SP_W-1:0] sp;
      logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
      logic [NREG-1:0][7:0] regs;
      logic [7:0] acc;
      logic carry;
      logic dcarry;
      logic zero;
      logic done;
      logic [7:0] peek;
   } core_t;

   core_t q;
   core_t d;

   // Returns {carry, digit carry, result} for a - b
   function automatic logic [9:0] sub8(input logic [7:0] a,
                                       input logic [7:0] b);
      logic [8:0] full;
      logic [4:0] nib;
      full = {1'b0, a} + {1'b0, ~b} + 9'h001;
      nib = {1'b0, a[`ARS_NIB_LO_MSB:0]} +
            {1'b0, ~b[`ARS_NIB_LO_MSB:0]} + 5'h01;
      return {full[8], nib[4], full[7:0]};
   endfunction

   function automatic logic is_zero(input logic [7:0] v);
      return v == 8'h00;
   endfunction

   logic [7:0] fval;
   logic [7:0] res;
   logic [9:0] sres;
   logic wr_res;
   logic dest_sel;

   always_comb begin
      d = q;
      d.done = 1'b0;
      fval = 8'h00;
      res = 8'h00;
      sres = 10'h000;
      wr_res = 1'b0;
      dest_sel = `ARS_DEST_ACC;
      o_ready = (q.st == mcu_alu_pkg::ST_IDLE);

      // Preloads land first, so an instruction result wins
      if (i_acc_wr) begin
         d.acc = i_acc_wdata;
      end
      if (i_file_wr) begin
         d.regs[i_file_waddr] = i_file_wdata;
      end

      fval = q.regs[i_faddr];

      case (q.st)
         mcu_alu_pkg::ST_IDLE: begin
            if (i_issue) begin
               d.done = 1'b1;
               d.pc = q.pc + PC_W'(1);
               case (i_op)
                  mcu_alu_pkg::OP_SUBROUTINE_EXIT: begin
                     d.sp = q.sp - SP_W'(1);
                     d.pc = q.stack[q.sp - SP_W'(1)];
                     d.done = 1'b0;
                     d.st = mcu_alu_pkg::ST_RET_WAIT;
                     d.wait_cnt = 2'(`ARS_RET_CYCLES - 1);
                  end
                  mcu_alu_pkg::OP_LITERAL_MINUS_ACC: begin
                     sres = sub8(i_literal, q.acc);
                     res = sres[7:0];
                     wr_res = 1'b1;
                     dest_sel = `ARS_DEST_ACC;
                     d.carry = sres[9];
                     d.dcarry = sres[8];
                     d.zero = is_zero(res);
                  end
                  mcu_alu_pkg::OP_FILE_MINUS_ACC: begin
                     sres = sub8(fval, q.acc);
                     res = sres[7:0];
                     wr_res = 1'b1;
                     dest_sel = i_dest;
                     d.carry = sres[9];
                     d.dcarry = sres[8];
                     d.zero = is_zero(res);
                  end
                  mcu_alu_pkg::OP_ROTATE_RIGHT_CARRY: begin
                     res = {q.carry, fval[`ARS_DATA_MSB:1]};
                     wr_res = 1'b1;
                     dest_sel = i_dest;
                     d.carry = fval[0];
                  end
                  mcu_alu_pkg::OP_NIBBLE_EXCHANGE: begin
                     res = {fval[`ARS_NIB_LO_MSB:0],
                            fval[`ARS_DATA_MSB:`ARS_NIB_HI_LSB]};
                     wr_res = 1'b1;
                     dest_sel = i_dest;
                  end
                  mcu_alu_pkg::OP_FILE_XOR_ACC: begin
                     res = q.acc ^ fval;
                     wr_res = 1'b1;
                     dest_sel = i_dest;
                     d.zero = is_zero(res);
                  end
                  mcu_alu_pkg::OP_LITERAL_XOR_ACC: begin
                     res = q.acc ^ i_literal;
                     wr_res = 1'b1;
                     dest_sel = `ARS_DEST_ACC;
                     d.zero = is_zero(res);
                  end
                  default: begin
                     d.done = 1'b1;
                  end
               endcase
            end else if (i_call) begin
               // Stack wraps when overfilled, oldest entry lost
               d.stack[q.sp] = i_call_return;
               d.sp = q.sp + SP_W'(1);
               d.pc = i_call_target;
            end
         end
         mcu_alu_pkg::ST_RET_WAIT: begin
            if (q.wait_cnt <= 2'h1) begin
               d.st = mcu_alu_pkg::ST_IDLE;
               d.done = 1'b1;
            end else begin
               d.wait_cnt = q.wait_cnt - 2'h1;
            end
         end
         default: begin
            d.st = mcu_alu_pkg::ST_IDLE;
         end
      endcase

      if (wr_res) begin
         if (dest_sel == `ARS_DEST_FILE) begin
            d.regs[i_faddr] = res;
         end else begin
            d.acc = res;
         end
      end

      d.peek = q.regs[i_peek_addr];

      if (i_srst) begin
         d = '0;
         d.st = mcu_alu_pkg::ST_IDLE;
         d.acc = `ARS_ACC_RST;
         d.carry = `ARS_FLAG_RST;
         d.dcarry = `ARS_FLAG_RST;
         d.zero = `ARS_FLAG_RST;
         for (int i = 0; i < NREG; i++) begin
            d.regs[i] = `ARS_FILE_RST;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      q <= d;
   end

   assign o_done = q.done;
   assign o_peek_data = q.peek;
   assign o_acc = q.acc;
   assign o_carry = q.carry;
   assign o_digit_carry_flag = q.dcarry;
   assign o_zero = q.zero;
   assign o_pc = q.pc;
   assign o_stack_ptr = q.sp;

endmodule // mcu_alu_return_subset

// file: mcu_alu_return_subset_consts.svh
`ifndef MCU_ALU_RETURN_SUBSET_CONSTS_SVH
`define MCU_ALU_RETURN_SUBSET_CONSTS_SVH

// Cycles from issue of subroutine_exit until the next issue
`define ARS_RET_CYCLES 2

// Destination select encoding
`define ARS_DEST_ACC 1'b0
`define ARS_DEST_FILE 1'b1

// Field positions
`define ARS_DATA_MSB 7
`define ARS_NIB_HI_LSB 4
`define ARS_NIB_LO_MSB 3

// Reset values
`define ARS_ACC_RST 8'h00
`define ARS_FLAG_RST 1'b0
`define ARS_FILE_RST 8'h00

`endif

// file: mcu_alu_pkg.sv
package mcu_alu_pkg;

   typedef enum logic [2:0] {
      OP_SUBROUTINE_EXIT = 3'h0,
      OP_LITERAL_MINUS_ACC = 3'h1,
      OP_FILE_MINUS_ACC = 3'h2,
      OP_ROTATE_RIGHT_CARRY = 3'h3,
      OP_NIBBLE_EXCHANGE = 3'h4,
      OP_FILE_XOR_ACC = 3'h5,
      OP_LITERAL_XOR_ACC = 3'h6,
      OP_NONE = 3'h7
   } op_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h1,
      ST_RET_WAIT = 2'h2
   } state_t;

endpackage

// file: mcu_alu_props.sv
`timescale 1ns/1ps
module mcu_alu_props #(
   parameter int SP_W = 3
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // Issue port
   input wire logic i_issue,
   input wire mcu_alu_pkg::op_t i_op,
   input wire logic [7:0] i_literal,
   input wire logic o_ready,
   input wire logic o_done,
   // Architectural state
   input wire logic [7:0] o_acc,
   input wire logic o_carry,
   input wire logic o_digit_carry_flag,
   input wire logic o_zero,
   input wire logic [SP_W-1:0] o_stack_ptr
);
   logic go, ex, ls, lx, sw, ro;
   logic [2:0] fl;
   assign go = i_issue && o_ready;
   assign ex = go && i_op == mcu_alu_pkg::OP_SUBROUTINE_EXIT;
   assign ls = go && i_op == mcu_alu_pkg::OP_LITERAL_MINUS_ACC;
   assign lx = go && i_op == mcu_alu_pkg::OP_LITERAL_XOR_ACC;
   assign sw = go && i_op == mcu_alu_pkg::OP_NIBBLE_EXCHANGE;
   assign ro = go && i_op == mcu_alu_pkg::OP_ROTATE_RIGHT_CARRY;
   assign fl = {o_carry, o_digit_carry_flag, o_zero};
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_srst);
   sequence exit_seq;
      !o_ready ##1 (o_ready && o_done);
   endsequence
   AST_EXIT_TWO: assert property (ex |=> exit_seq)
      else $error("exit length wrong");
   AST_EXIT_POP: assert property (ex |=>
      o_stack_ptr == SP_W'($past(o_stack_ptr) - 1'b1)) else $error("no pop");
   AST_EXIT_FLAGS: assert property (ex |=> fl == $past(fl))
      else $error("exit moved flags");
   AST_LSUB: assert property (ls |=>
      o_acc == 8'($past(i_literal) - $past(o_acc))
      && o_carry == ($past(i_literal) >= $past(o_acc))) else $error("sub bad");
   AST_LSUB_DC: assert property (ls |=> o_zero == (o_acc == 8'h00) &&
      o_digit_carry_flag == ($past(i_literal[3:0]) >= $past(o_acc[3:0])))
      else $error("sub flags bad");
   AST_LXOR: assert property (lx |=> o_acc == ($past(i_literal) ^
      $past(o_acc)) && o_zero == (o_acc == 8'h00) && fl[2:1] == $past(fl[2:1]))
      else $error("xor bad");
   AST_SWAP: assert property (sw |=> $stable(fl))
      else $error("swap moved flags");
   AST_ROT: assert property (ro |=> $stable(fl[1:0]))
      else $error("rotate moved flags");
endmodule // mcu_alu_props

bind mcu_alu_return_subset mcu_alu_props #(.SP_W(SP_W)) props_i (.i_clk_sys,
   .i_srst, .i_issue, .o_ready, .o_done, .i_op, .i_literal, .o_acc, .o_carry,
   .o_digit_carry_flag, .o_zero, .o_stack_ptr);

// file: mcu_alu_return_subset_tb.sv
`timescale 1ns/1ps
module mcu_alu_return_subset_tb;
   typedef struct packed {logic [2:0] op; logic [7:0] a, f, k;
      logic [6:0] fa; logic d; logic [7:0] r; logic [2:0] fl;} row_t;
   // Flags column is carry, digit carry, zero; carry chains row to row
   row_t rows [11] = '{{3'h1, 8'h01, 8'h00, 8'h10, 7'h00, 1'b0, 8'h0f, 3'h4},
      {3'h2, 8'h05, 8'h05, 8'h00, 7'h7f, 1'b1, 8'h00, 3'h7},
      {3'h3, 8'h00, 8'h01, 8'h00, 7'h00, 1'b0, 8'h80, 3'h7},
      {3'h3, 8'h00, 8'h02, 8'h00, 7'h10, 1'b1, 8'h81, 3'h3},
      {3'h4, 8'h00, 8'ha5, 8'h00, 7'h20, 1'b1, 8'h5a, 3'h3},
      {3'h6, 8'h0f, 8'h00, 8'hf0, 7'h00, 1'b0, 8'hff, 3'h2},
      {3'h5, 8'hff, 8'hff, 8'h00, 7'h30, 1'b0, 8'h00, 3'h3},
      {3'h2, 8'h01, 8'h00, 8'h00, 7'h40, 1'b0, 8'hff, 3'h0},
      {3'h3, 8'h00, 8'h03, 8'h00, 7'h60, 1'b0, 8'h01, 3'h4},
      {3'h1, 8'h00, 8'h00, 8'hff, 7'h00, 1'b0, 8'hff, 3'h6},
      {3'h4, 8'h00, 8'h0f, 8'h00, 7'h50, 1'b0, 8'hf0, 3'h6}};
   row_t r;
   logic i_clk_sys = 0, i_srst = 1, i_issue = 0, i_dest = 0, i_call = 0;
   logic i_acc_wr = 0, i_file_wr = 0, o_ready, o_done;
   logic o_carry, o_digit_carry_flag, o_zero;
   mcu_alu_pkg::op_t i_op = mcu_alu_pkg::OP_NONE;
   logic [7:0] i_literal = '0, i_acc_wdata = '0, i_file_wdata = '0;
   logic [7:0] o_peek_data, o_acc;
   logic [6:0] i_faddr = '0, i_file_waddr = '0, i_peek_addr = '0;
   logic [12:0] i_call_target = '0, i_call_return = '0, o_pc;
   logic [2:0] o_stack_ptr;
   int fail_count = 0, check_count = 0, cyc = 0;
   mcu_alu_return_subset dut (.i_clk_sys, .i_srst, .i_issue, .i_op, .i_literal,
      .i_faddr, .i_dest, .o_ready, .o_done, .i_call, .i_call_target,
      .i_call_return, .i_acc_wr, .i_acc_wdata, .i_file_wr, .i_file_waddr,
      .i_file_wdata, .i_peek_addr, .o_peek_data, .o_acc, .o_carry,
      .o_digit_carry_flag, .o_zero, .o_pc, .o_stack_ptr);
   initial begin
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Whole run needs about seventy cycles
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 500) begin
         fail_count++;
         tally_and_finish;
      end
   end
   task automatic chk(input logic [12:0] g, input logic [12:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("FAIL %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_f(input logic [2:0] e);
      chk({10'h000, o_carry, o_digit_carry_flag, o_zero}, {10'h000, e});
   endtask
   initial begin
      repeat (20) @(negedge i_clk_sys);
      i_srst = 0;
      foreach (rows[n]) begin
         r = rows[n];
         @(negedge i_clk_sys);
         {i_acc_wr, i_file_wr, i_acc_wdata, i_file_waddr, i_file_wdata} =
            {2'b11, r.a, r.fa, r.f};
         @(negedge i_clk_sys);
         {i_acc_wr, i_file_wr, i_issue, i_literal, i_faddr, i_dest} =
            {3'b001, r.k, r.fa, r.d};
         i_op = mcu_alu_pkg::op_t'(r.op);
         i_peek_addr = r.fa;
         @(negedge i_clk_sys);
         i_issue = 0;
         chk_f(r.fl);
         chk(o_done, 1'b1);
         if (r.d) begin
            chk(o_acc, r.a);
            @(negedge i_clk_sys);
            chk(o_peek_data, r.r);
         end else begin
            chk(o_acc, r.r);
         end
      end
      chk(o_pc, 13'h000b);
      {i_call, i_call_target, i_call_return} = {1'b1, 13'h0100, 13'h0abc};
      @(negedge i_clk_sys);
      i_call_return = 13'h0123;
      @(negedge i_clk_sys);
      {i_call, i_issue} = 2'b01;
      i_op = mcu_alu_pkg::OP_SUBROUTINE_EXIT;
      @(negedge i_clk_sys);
      chk(o_ready, 1'b0);
      chk(o_pc, 13'h0123);
      chk(o_stack_ptr, 13'h0001);
      // Refused while the exit is still running
      i_op = mcu_alu_pkg::OP_LITERAL_XOR_ACC;
      i_literal = 8'hff;
      @(negedge i_clk_sys);
      chk(o_done, 1'b1);
      chk(o_acc, 13'h00f0);
      i_op = mcu_alu_pkg::OP_SUBROUTINE_EXIT;
      @(negedge i_clk_sys);
      i_issue = 0;
      chk(o_pc, 13'h0abc);
      chk(o_stack_ptr, 13'h0000);
      chk_f(3'h6);
      @(negedge i_clk_sys);
      chk(o_done, 1'b1);
      // Instruction beats a same-edge preload; call refused while issuing
      {i_acc_wr, i_acc_wdata, i_call, i_issue} = {1'b1, 8'h11, 2'b11};
      i_op = mcu_alu_pkg::OP_LITERAL_XOR_ACC;
      @(negedge i_clk_sys);
      {i_acc_wr, i_call} = 2'b00;
      i_op = mcu_alu_pkg::OP_NONE;
      chk(o_acc, 13'h000f);
      chk(o_pc, 13'h0abd);
      chk(o_stack_ptr, 13'h0000);
      chk_f(3'h6);
      // Unused opcode only advances the counter
      @(negedge i_clk_sys);
      i_issue = 0;
      chk(o_pc, 13'h0abe);
      chk(o_done, 1'b1);
      chk(o_acc, 13'h000f);
      chk_f(3'h6);
      i_srst = 1;
      repeat (2) @(negedge i_clk_sys);
      chk({o_acc, o_pc[4:0]}, 13'h0000);
      chk({o_stack_ptr, o_ready}, 13'h0001);
      chk_f(3'h0);
      tally_and_finish;
   end
endmodule // mcu_alu_return_subset_tb
